/* hw/rx_signal_ctrl.v */
/*
 * Receive robbed-bit signaling substitution and extraction control for
 * 24 channels: control registers, substitution values, signaling array,
 * PCM signaling substitution and extracted-signaling outputs.
 * Assumes the framer presents one channel's ABCD per cycle with a strobe
 * and a channel number, and one separate PCM-side ABCD path with its own channel number.
 */
// Implementation choices: the strobed register port and the register offsets.
// Behaviour
// - Format 00 with substitution active replaces every received signaling bit with one.
// - Format 01 substitutes A, B, C, D; software loads substitute value bits 3-0.
// - Format 10 substitutes only A and B from the substitute value register.
// - Format 11 substitutes only A from the substitute value register.
// - Extraction format 00 extracts no signaling for the channel.
// - Extraction format 01 extracts all four bits A, B, C, D.
// - Extraction format 10 extracts only bits A and B.
// - Extraction format 11 extracts only bit A.
// - Extracted signaling goes to array, signaling pin if enabled, overhead if enabled.
// - Independent two-bit substitution (3-2) and extraction (1-0) fields, reset 00.
// - Substitution needs its enable and alters only the PCM output.
// - Substitute values: A bit 3, B bit 2, C bit 1, D bit 0.
// - With debounce, update array and pin after two equal consecutive superframes.
`timescale 1ns/1ns
`include "rx_sig_regs.vh"
module rx_signal_ctrl (
    clock,
    resetn,
    reg_addr,
    reg_wdata,
    reg_write,
    reg_read,
    reg_rdata,
    rx_sig_valid,
    rx_sig_chan,
    rx_sig_abcd,
    rx_sig_superframe,
    pcm_chan,
    pcm_sig_in,
    pcm_rx_serial_sig,
    signal_out_pin_valid,
    signal_out_pin_chan,
    signal_out_pin,
    overhead_out_pin_valid,
    overhead_out_pin
);
    input  wire [`ADDR_BITS-1:0]  reg_addr;
    input  wire                   clock;
    input  wire                   resetn;
    input  wire [7:0]             reg_wdata;
    input  wire                   reg_write;
    input  wire                   reg_read;
    output reg  [7:0]             reg_rdata;
    input  wire                   rx_sig_valid;
    input  wire [`CHAN_BITS-1:0]  rx_sig_chan;
    input  wire [3:0]             rx_sig_abcd;
    input  wire                   rx_sig_superframe;
    input  wire [`CHAN_BITS-1:0]  pcm_chan;
    input  wire [3:0]             pcm_sig_in;
    output reg  [3:0]             pcm_rx_serial_sig;
    output reg                    signal_out_pin_valid;
    output reg  [`CHAN_BITS-1:0]  signal_out_pin_chan;
    output reg  [3:0]             signal_out_pin;
    output reg                    overhead_out_pin_valid;
    output reg  [3:0]             overhead_out_pin;

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    reg  [6:0]  ctrl_q      [0:`NUM_CHANNELS-1];
    reg  [3:0]  subst_val_q [0:`NUM_CHANNELS-1];
    reg         sig_if_en_q;
    wire [3:0]  array_abcd  [0:`NUM_CHANNELS-1];

    wire [7:0]  ctrl_off  = reg_addr - `CTRL_BASE;
    wire [7:0]  subst_off = reg_addr - `SUBST_VAL_BASE;
    wire [7:0]  array_off = reg_addr - `SIG_ARRAY_BASE;
    wire        hit_ctrl  = (reg_addr >= `CTRL_BASE) && (ctrl_off < 8'h18);
    wire        hit_subst = (reg_addr >= `SUBST_VAL_BASE) && (subst_off < 8'h18);
    wire        hit_array = (reg_addr >= `SIG_ARRAY_BASE) && (array_off < 8'h18);

    // ------------------------------------------------------------------------
    // Extraction masking
    // ------------------------------------------------------------------------
    function [3:0] extract_mask;
        input [1:0] fmt;
        begin
            case (fmt)
                `FMT_NONE:   extract_mask = 4'h0;
                `FMT_16CODE: extract_mask = 4'hf;
                `FMT_4CODE:  extract_mask = 4'hc;
                default:     extract_mask = 4'h8;
            endcase
        end
    endfunction

    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1) begin : g_chan
            wire [6:0] c    = ctrl_q[ch];
            wire       hit  = rx_sig_valid && (rx_sig_chan == ch);
            // Bits outside the chosen format read as zero in the array
            wire [3:0] extr = rx_sig_abcd & extract_mask(c[`EXTR_FMT_HI:`EXTR_FMT_LO]);

            always @(posedge clock) begin
                if (!resetn) begin
                    ctrl_q[ch]      <= 7'h00;
                    subst_val_q[ch] <= `SUBST_VAL_RESET;
                end else if (reg_write) begin
                    if (hit_ctrl && ctrl_off[4:0] == ch) begin
                        ctrl_q[ch] <= reg_wdata[6:0];
                    end
                    if (hit_subst && subst_off[4:0] == ch) begin
                        subst_val_q[ch] <= reg_wdata[3:0];
                    end
                end
            end

            // Format 00 skips the array update entirely
            sig_debounce u_deb (
                .clock        (clock),
                .resetn       (resetn),
                .sample_valid (hit && rx_sig_superframe &&
                               (c[`EXTR_FMT_HI:`EXTR_FMT_LO] != `FMT_NONE)),
                .sample_abcd  (extr),
                .deb_en       (c[`DEB_EN_BIT]),
                .held_abcd    (array_abcd[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------
    always @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            if (hit_ctrl) begin
                reg_rdata <= {1'b0, ctrl_q[ctrl_off[4:0]]};
            end else if (hit_subst) begin
                reg_rdata <= {4'h0, subst_val_q[subst_off[4:0]]};
            end else if (hit_array) begin
                reg_rdata <= {4'h0, array_abcd[array_off[4:0]]};
            end else if (reg_addr == `GLOBAL_CFG_ADDR) begin
                reg_rdata <= {7'h00, sig_if_en_q};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    always @(posedge clock) begin
        if (!resetn) begin
            sig_if_en_q <= `GLOBAL_CFG_RESET;
        end else if (reg_write && reg_addr == `GLOBAL_CFG_ADDR) begin
            sig_if_en_q <= reg_wdata[`SIG_IF_EN_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // PCM signaling substitution
    // ------------------------------------------------------------------------
    wire [6:0] pc = ctrl_q[pcm_chan];
    wire [3:0] sv = subst_val_q[pcm_chan];
    reg  [3:0] pcm_d;

    always @* begin
        pcm_d = pcm_sig_in;
        if (pc[`SUBST_EN_BIT]) begin
            case (pc[`SUBST_FMT_HI:`SUBST_FMT_LO])
                `FMT_NONE:   pcm_d = 4'hf;
                `FMT_16CODE: pcm_d = {sv[`SIG_A_BIT], sv[`SIG_B_BIT],
                                      sv[`SIG_C_BIT], sv[`SIG_D_BIT]};
                `FMT_4CODE:  pcm_d = {sv[`SIG_A_BIT], sv[`SIG_B_BIT], pcm_sig_in[1:0]};
                default:     pcm_d = {sv[`SIG_A_BIT], pcm_sig_in[2:0]};
            endcase
        end
    end

    always @(posedge clock) begin
        if (!resetn) begin
            pcm_rx_serial_sig <= 4'h0;
        end else begin
            pcm_rx_serial_sig <= pcm_d;
        end
    end

    // ------------------------------------------------------------------------
    // Extracted signaling outputs
    // ------------------------------------------------------------------------
    // Substituted values never reach these; they read the array only
    wire [6:0] rc     = ctrl_q[rx_sig_chan];
    wire       r_extr = rx_sig_valid && (rc[`EXTR_FMT_HI:`EXTR_FMT_LO] != `FMT_NONE);

    always @(posedge clock) begin
        if (!resetn) begin
            signal_out_pin_valid   <= 1'b0;
            signal_out_pin_chan    <= {`CHAN_BITS{1'b0}};
            signal_out_pin         <= 4'h0;
            overhead_out_pin_valid <= 1'b0;
            overhead_out_pin       <= 4'h0;
        end else begin
            signal_out_pin_valid   <= r_extr && sig_if_en_q;
            signal_out_pin_chan    <= rx_sig_chan;
            signal_out_pin         <= array_abcd[rx_sig_chan];
            overhead_out_pin_valid <= r_extr && rc[`OH_EN_BIT];
            overhead_out_pin       <= array_abcd[rx_sig_chan];
        end
    end
endmodule

/* hw/rx_sig_regs.vh */
/*
 * Register offsets, field positions, reset values and encodings for the
 * receive signaling channel control block.
 * Assumes a byte-wide register port and 24 DS0 channels.
 */
`ifndef RX_SIG_REGS_VH
`define RX_SIG_REGS_VH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define NUM_CHANNELS        24
`define CHAN_BITS           5
`define ADDR_BITS           8

// ----------------------------------------------------------------------------
// Register offsets (channel n at base + n)
// ----------------------------------------------------------------------------
`define CTRL_BASE           8'h00
`define SUBST_VAL_BASE      8'h20
`define SIG_ARRAY_BASE      8'h40
`define GLOBAL_CFG_ADDR     8'h60

// ----------------------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------------------
`define SUBST_EN_BIT        6
`define OH_EN_BIT           5
`define DEB_EN_BIT          4
`define SUBST_FMT_HI        3
`define SUBST_FMT_LO        2
`define EXTR_FMT_HI         1
`define EXTR_FMT_LO         0
`define CTRL_RESET          8'h00
`define CTRL_WMASK          8'h7f

// ----------------------------------------------------------------------------
// Substitution value fields and array
// ----------------------------------------------------------------------------
`define SIG_A_BIT           3
`define SIG_B_BIT           2
`define SIG_C_BIT           1
`define SIG_D_BIT           0
`define SUBST_VAL_RESET     4'h0
`define SIG_ARRAY_RESET     4'h0

// ----------------------------------------------------------------------------
// Global configuration
// ----------------------------------------------------------------------------
`define SIG_IF_EN_BIT       0
`define GLOBAL_CFG_RESET    1'b0

// ----------------------------------------------------------------------------
// Format encodings (substitution and extraction share them)
// ----------------------------------------------------------------------------
`define FMT_NONE            2'h0
`define FMT_16CODE          2'h1
`define FMT_4CODE           2'h2
`define FMT_2CODE           2'h3

`endif

/* hw/sig_debounce.v */
/*
 * Per-channel signaling state holder with optional two-superframe debounce.
 * Assumes the superframe strobe marks when a channel's ABCD sample is final.
 */
`timescale 1ns/1ns
`include "rx_sig_regs.vh"
module sig_debounce (
    clock,
    resetn,
    sample_valid,
    sample_abcd,
    deb_en,
    held_abcd
);
    input  wire       clock;
    input  wire       resetn;
    input  wire       sample_valid;
    input  wire [3:0] sample_abcd;
    input  wire       deb_en;
    output wire [3:0] held_abcd;

    reg [3:0] last_q;
    reg [3:0] held_q;

    assign held_abcd = held_q;

    always @(posedge clock) begin
        if (!resetn) begin
            last_q <= `SIG_ARRAY_RESET;
            held_q <= `SIG_ARRAY_RESET;
        end else if (sample_valid) begin
            last_q <= sample_abcd;
            // With debounce on, unequal consecutive superframes leave the held state alone
            if (!deb_en || (sample_abcd == last_q)) begin
                held_q <= sample_abcd;
            end
        end
    end
endmodule

/* dv/rx_signal_ctrl_asserts.sv */
/* Port-level checker for rx_signal_ctrl.
   Assumes channel numbers 0-23 and the register offsets of rx_sig_regs.vh. */
`timescale 1ns/1ns
module rx_signal_ctrl_asserts (
    input wire       clock,
    input wire       resetn,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_write,
    input wire       reg_read,
    input wire [7:0] reg_rdata,
    input wire       rx_sig_valid,
    input wire [4:0] rx_sig_chan,
    input wire [4:0] pcm_chan,
    input wire [3:0] pcm_sig_in,
    input wire [3:0] pcm_rx_serial_sig,
    input wire       signal_out_pin_valid,
    input wire [4:0] signal_out_pin_chan,
    input wire       overhead_out_pin_valid
);
    // ----------
    // Shadow of control and global enable
    // ----------
    reg  [6:0] ctl_q [0:31];
    reg        gen_q;
    integer    i;
    wire [6:0] rc = ctl_q[rx_sig_chan];
    wire [6:0] pc = ctl_q[pcm_chan];
    always @(posedge clock) begin
        if (!resetn) begin
            for (i = 0; i < 32; i = i + 1) begin
                ctl_q[i] <= 7'h00;
            end
            gen_q <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr < 8'h18)
                ctl_q[reg_addr[4:0]] <= reg_wdata[6:0];
            if (reg_addr == 8'h60)
                gen_q <= reg_wdata[0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    a_rdata_idle_zero: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero");
    a_extract_none: assert property (rx_sig_valid && rc[1:0] == 2'h0 |=>
        !signal_out_pin_valid && !overhead_out_pin_valid) else $error("output without extraction");
    a_pin_follows: assert property (rx_sig_valid && rc[1:0] != 2'h0 && gen_q |=>
        signal_out_pin_valid && signal_out_pin_chan == $past(rx_sig_chan)) else $error("pin missed");
    a_oh_follows: assert property (rx_sig_valid && rc[1:0] != 2'h0 && rc[5] |=>
        overhead_out_pin_valid) else $error("overhead missed");
    a_pin_cause: assert property (signal_out_pin_valid |->
        $past(rx_sig_valid) && $past(gen_q)) else $error("pin without cause");
    a_pcm_through: assert property (!pc[6] |=>
        pcm_rx_serial_sig == $past(pcm_sig_in)) else $error("pcm altered");
    a_subst_ones: assert property (pc[6] && pc[3:2] == 2'h0 |=>
        pcm_rx_serial_sig == 4'hf) else $error("ones missing");
    a_subst_ab: assert property (pc[6] && pc[3:2] == 2'h2 |=>
        ((pcm_rx_serial_sig ^ $past(pcm_sig_in)) & 4'h3) == 4'h0) else $error("c d altered");
    a_subst_a: assert property (pc[6] && pc[3:2] == 2'h3 |=>
        ((pcm_rx_serial_sig ^ $past(pcm_sig_in)) & 4'h7) == 4'h0) else $error("b c d altered");
    c_pin: cover property (signal_out_pin_valid);
    c_oh: cover property (overhead_out_pin_valid);
    c_ones: cover property (pc[6] && pc[3:2] == 2'h0);
endmodule
bind rx_signal_ctrl rx_signal_ctrl_asserts u_chk (.*);

/* dv/rx_framer_model.sv */
/* Framer-side model: presents received ABCD samples and PCM signaling.
   Assumes the caller gives channels 0-23. */
`timescale 1ns/1ns
module rx_framer_model (
    input  wire       clock,
    output reg        rx_sig_valid,
    output reg  [4:0] rx_sig_chan,
    output reg  [3:0] rx_sig_abcd,
    output reg        rx_sig_superframe,
    output reg  [4:0] pcm_chan,
    output reg  [3:0] pcm_sig_in
);
    initial begin
        rx_sig_valid = 1'b0;
        rx_sig_chan = 5'h00;
        rx_sig_abcd = 4'h0;
        rx_sig_superframe = 1'b0;
        pcm_chan = 5'h00;
        pcm_sig_in = 4'h0;
    end
    task send(input [4:0] ch, input [3:0] v);
        @(posedge clock);
        rx_sig_valid <= 1'b1;
        rx_sig_chan <= ch;
        rx_sig_abcd <= v;
        rx_sig_superframe <= 1'b1;
        @(posedge clock);
        rx_sig_valid <= 1'b0;
        // Released lines show the inverse, never a stale copy
        rx_sig_abcd <= ~v;
    endtask
    task pcm(input [4:0] ch, input [3:0] v);
        @(posedge clock);
        pcm_chan <= ch;
        pcm_sig_in <= v;
        @(posedge clock);
    endtask
endmodule

/* dv/tb_top.sv */
/* Bench for rx_signal_ctrl with an integer reference model.
   Assumes the framer model drives all receive-side inputs. */
`timescale 1ns/1ns
module tb_top;
    reg        clock = 1'b0;
    reg        resetn = 1'b0;
    reg  [7:0] reg_addr = 8'h00;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_write = 1'b0;
    reg        reg_read = 1'b0;
    wire [7:0] reg_rdata;
    wire [4:0] rx_sig_chan, pcm_chan, signal_out_pin_chan;
    wire [3:0] rx_sig_abcd, pcm_sig_in, pcm_rx_serial_sig, signal_out_pin, overhead_out_pin;
    wire       rx_sig_valid, rx_sig_superframe, signal_out_pin_valid, overhead_out_pin_valid;
    integer    ctl [0:23];
    integer    sv [0:23];
    integer    arr [0:23];
    integer    seed = 32'h7bf7;
    integer    fails = 0;
    integer    num_checks = 0;
    integer    ch, j, e, s, v, x, mk;
    rx_signal_ctrl DUT (.*);
    rx_framer_model u_frm (.*);
    always #2 clock = ~clock;
    // ----------
    // Checks and register bus
    // ----------
    task check(input [7:0] seen, input [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task summarize;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        for (ch = 0; ch < 24; ch = ch + 1) begin
            arr[ch] = 0;
            rd(ch, 0);
            rd(8'h20 + ch, 0);
            rd(8'h40 + ch, 0);
        end
        wr(8'h60, 8'h01);
        rd(8'h70, 0);
        // Channel number encodes both formats: bits 3-2 subst, 1-0 extract
        for (ch = 0; ch < 16; ch = ch + 1) begin
            e = ch & 3;
            s = ch >> 2;
            mk = (e == 1) ? 15 : (e == 2) ? 12 : (e == 3) ? 8 : 0;
            ctl[ch] = 8'h40 | ((ch & 4) << 3) | ch;
            sv[ch] = $random(seed) & 15;
            wr(ch, ctl[ch] | 8'h80);
            wr(8'h20 + ch, sv[ch] | 8'hf0);
            rd(ch, ctl[ch]);
            rd(8'h20 + ch, sv[ch]);
            for (j = 0; j < 2; j = j + 1) begin
                v = $random(seed) & 15;
                u_frm.send(ch, v);
                #1 check(signal_out_pin_valid, e != 0);
                check(overhead_out_pin_valid, e != 0 && ch[2]);
                if (e != 0) check(signal_out_pin, arr[ch]);
                if (ch[2] && e != 0) check(overhead_out_pin, arr[ch]);
                arr[ch] = (e == 0) ? arr[ch] : v & mk;
            end
            rd(8'h40 + ch, arr[ch]);
            v = $random(seed) & 15;
            x = (s == 0) ? 15 : (s == 1) ? sv[ch] : (s == 2) ? (sv[ch] & 12 | v & 3) : (sv[ch] & 8 | v & 7);
            u_frm.pcm(ch, v);
            #1 check(pcm_rx_serial_sig, x);
            wr(ch, ctl[ch] & 8'h3f);
            u_frm.pcm(ch, v);
            #1 check(pcm_rx_serial_sig, v);
        end
        wr(20, 8'h11);
        u_frm.send(20, 5);
        rd(8'h40 + 20, 0);
        u_frm.send(20, 5);
        rd(8'h40 + 20, 5);
        summarize;
    end
endmodule
